/* File: pcb_config_forward.v */
// Overview of operation
// RL1: Type 0 produced only on secondary bus
// RL2: Claim primary Type 1 matching secondary bus
// RL3: Clear low bits, 15:11; keep function, register
// RL4: Devices 0-15 get one-hot select line
// RL5: Devices 10h-1Eh: no select, still forwarded
// RL6: Device 1Fh register zero makes special cycle
// RL7: Unselected translated access ends master abort
// RL8: Translated accesses delayed, one data phase
// RL9: Forward deeper bus numbers downstream unchanged
// RL10: All-ones writes outside range go upstream
// RL11: Type 1 forwarded writes delayed, single phase
// RL12: Incoming special cycles ignored, never forwarded
// RL13: All-ones register-zero write becomes special cycle
// RL14: Special cycle keeps address and data
// RL15: Special master abort hidden; repeat gets TRDY
// RL16: Multi-phase special write gets disconnect
// RL17: Unmatched Type 1 accesses are not claimed
`timescale 1ns/1ps
`default_nettype none
`include "pcb_cfg_map.vh"

module pcb_config_forward
(
  input  wire        clock,
  input  wire        reset,
  input  wire        clockEnable,
  input  wire [7:0]  primaryBusNumber,
  input  wire [7:0]  secondaryBusNumber,
  input  wire [7:0]  subordinateBusNumber,
  input  wire        primAddrValid,
  input  wire [31:0] primAddr,
  input  wire [3:0]  primary_cmd_byte_enable,
  input  wire [31:0] primData,
  input  wire        primMultiPhase,
  input  wire        secAddrValid,
  input  wire [31:0] secAddr,
  input  wire [3:0]  cmd_byte_enable_lines,
  input  wire [31:0] secData,
  input  wire        secMultiPhase,
  input  wire        tgtDone,
  input  wire        tgtMasterAbort,
  input  wire [31:0] tgtReadData,
  output reg         primRespValid,
  output reg  [1:0]  primRespCode,
  output reg         primRespDisconnect,
  output reg  [31:0] primReadData,
  output reg         secRespValid,
  output reg  [1:0]  secRespCode,
  output reg         secRespDisconnect,
  output reg  [31:0] secReadData,
  output reg         fwdValid,
  output reg         fwdToSecondary,
  output reg  [31:0] fwdAddr,
  output reg  [3:0]  fwdCmd,
  output reg  [31:0] fwdData,
  output reg         entryBusy
);

  // ************************************************************
  // Delayed transaction states
  // ************************************************************
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_ISSUE = 2'h1;
  localparam [1:0] ST_WAIT  = 2'h2;
  localparam [1:0] ST_DONE  = 2'h3;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg         entrySide;
  reg  [31:0] entryAddr;
  reg  [3:0]  entryCmd;
  reg  [31:0] entryData;
  reg  [1:0]  entryAction;
  reg  [31:0] entryReadData;

  wire [15:0] idselPattern;
  wire        primClaim;
  wire [1:0]  primAction;
  wire [31:0] primOutAddr;
  wire [3:0]  primOutCmd;
  wire        primToSec;
  wire        secClaim;
  wire [1:0]  secAction;
  wire [31:0] secOutAddr;
  wire [3:0]  secOutCmd;
  wire        secToSec;

  // ************************************************************
  // Address decoding
  // ************************************************************
  // Select pattern from the primary device number
  pcb_idsel_decode uIdsel
  (
    .deviceNumber (primAddr[`PCB_DEV_HI:`PCB_DEV_LO]),
    .idselPattern (idselPattern)
  );

  // Primary side classification
  pcb_cfg_classify uPrimClass
  (
    .fromPrimary          (1'b1),
    .addr                 (primAddr),
    .cmd                  (primary_cmd_byte_enable),
    .primaryBusNumber     (primaryBusNumber),
    .secondaryBusNumber   (secondaryBusNumber),
    .subordinateBusNumber (subordinateBusNumber),
    .idselPattern         (idselPattern),
    .claim                (primClaim),
    .action               (primAction),
    .outAddr              (primOutAddr),
    .outCmd               (primOutCmd),
    .toSecondary          (primToSec)
  );

  // Secondary side classification, never translates
  pcb_cfg_classify uSecClass
  (
    .fromPrimary          (1'b0),
    .addr                 (secAddr),
    .cmd                  (cmd_byte_enable_lines),
    .primaryBusNumber     (primaryBusNumber),
    .secondaryBusNumber   (secondaryBusNumber),
    .subordinateBusNumber (subordinateBusNumber),
    .idselPattern         (16'h0000),
    .claim                (secClaim),
    .action               (secAction),
    .outAddr              (secOutAddr),
    .outCmd               (secOutCmd),
    .toSecondary          (secToSec)
  );

  // ************************************************************
  // Request matching
  // ************************************************************
  // Repeat of the queued request by the same side
  function entryMatch;
    input        side;
    input [31:0] addr;
    input [3:0]  cmd;
    input [31:0] data;
    begin
      entryMatch = (side == entrySide) && (addr == entryAddr) && (cmd == entryCmd)
                   && ((cmd != `PCB_CMD_CFG_WRITE) || (data == entryData));
    end
  endfunction

  wire primHit    = primAddrValid && primClaim;
  wire secHit     = secAddrValid && secClaim;
  wire primRepeat = entryMatch(1'b1, primAddr, primary_cmd_byte_enable, primData);
  wire secRepeat  = entryMatch(1'b0, secAddr, cmd_byte_enable_lines, secData);
  wire primFinish = primHit && (state == ST_DONE) && primRepeat;
  wire secFinish  = secHit && (state == ST_DONE) && secRepeat && !primFinish;
  wire primQueue  = primHit && (state == ST_IDLE);
  wire secQueue   = secHit && (state == ST_IDLE) && !primQueue;

  // ************************************************************
  // Delayed transaction sequencing
  // ************************************************************
  // Next state of the single delayed entry
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (primQueue || secQueue)
        begin
          next_state = ST_ISSUE;  // see RL8 RL11
        end
      end
      ST_ISSUE:
      begin
        next_state = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (tgtDone)
        begin
          next_state = ST_DONE;
        end
      end
      ST_DONE:
      begin
        if (primFinish || secFinish)
        begin
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Entry capture and state register
  always @(posedge clock)
  begin
    if (reset)
    begin
      state         <= ST_IDLE;
      entrySide     <= 1'b0;
      entryAddr     <= 32'h00000000;
      entryCmd      <= 4'h0;
      entryData     <= 32'h00000000;
      entryAction   <= `PCB_ACT_TRANSLATE;
      entryReadData <= 32'h00000000;
      entryBusy     <= 1'b0;
    end
    else if (clockEnable)
    begin
      state     <= next_state;
      entryBusy <= (next_state != ST_IDLE);
      if (primQueue)
      begin
        entrySide   <= 1'b1;
        entryAddr   <= primAddr;
        entryCmd    <= primary_cmd_byte_enable;
        entryData   <= primData;
        entryAction <= primAction;
      end
      else if (secQueue)
      begin
        entrySide   <= 1'b0;
        entryAddr   <= secAddr;
        entryCmd    <= cmd_byte_enable_lines;
        entryData   <= secData;
        entryAction <= secAction;
      end
      if ((state == ST_WAIT) && tgtDone)
      begin
        // No select reached a device: all-ones read data; see RL7
        entryReadData <= tgtMasterAbort ? `PCB_RESP_ABORT_DATA : tgtReadData;
      end
    end
  end

  // ************************************************************
  // Target bus request
  // ************************************************************
  // One single-phase cycle per queued entry
  always @(posedge clock)
  begin
    if (reset)
    begin
      fwdValid       <= 1'b0;
      fwdToSecondary <= 1'b0;
      fwdAddr        <= 32'h00000000;
      fwdCmd         <= 4'h0;
      fwdData        <= 32'h00000000;
    end
    else if (clockEnable)
    begin
      fwdValid <= 1'b0;
      if (primQueue)
      begin
        fwdToSecondary <= primToSec;     // see RL1
        fwdAddr        <= primOutAddr;   // see RL3 RL4 RL5
        fwdCmd         <= primOutCmd;    // see RL14
        fwdData        <= primData;      // see RL14
      end
      else if (secQueue)
      begin
        fwdToSecondary <= secToSec;
        fwdAddr        <= secOutAddr;    // see RL10
        fwdCmd         <= secOutCmd;     // see RL14
        fwdData        <= secData;
      end
      if (state == ST_ISSUE)
      begin
        fwdValid <= 1'b1;  // see RL8 RL11
      end
    end
  end

  // ************************************************************
  // Initiator answers
  // ************************************************************
  // Answer code for a claimed address phase
  function [1:0] answerCode;
    input hit;
    input finish;
    begin
      if (!hit)
      begin
        answerCode = `PCB_RESP_NONE;  // see RL12 RL17
      end
      else if (finish)
      begin
        answerCode = `PCB_RESP_TRDY;  // see RL15
      end
      else
      begin
        answerCode = `PCB_RESP_RETRY;
      end
    end
  endfunction

  // Registered answers on both initiator buses
  always @(posedge clock)
  begin
    if (reset)
    begin
      primRespValid      <= 1'b0;
      primRespCode       <= `PCB_RESP_NONE;
      primRespDisconnect <= 1'b0;
      primReadData       <= 32'h00000000;
      secRespValid       <= 1'b0;
      secRespCode        <= `PCB_RESP_NONE;
      secRespDisconnect  <= 1'b0;
      secReadData        <= 32'h00000000;
    end
    else if (clockEnable)
    begin
      primRespValid      <= primAddrValid;
      primRespCode       <= answerCode(primHit, primFinish);
      primRespDisconnect <= primFinish && primMultiPhase;  // see RL8 RL16
      primReadData       <= primFinish ? entryReadData : 32'h00000000;
      secRespValid       <= secAddrValid;
      secRespCode        <= answerCode(secHit, secFinish);
      secRespDisconnect  <= secFinish && secMultiPhase;    // see RL11 RL16
      secReadData        <= secFinish ? entryReadData : 32'h00000000;
    end
  end

endmodule // pcb_config_forward

`default_nettype wire

/* File: pcb_cfg_map.vh */
`ifndef PCB_CFG_MAP_VH
`define PCB_CFG_MAP_VH

// ************************************************************
// Bus commands
// ************************************************************
`define PCB_CMD_SPECIAL     4'h1
`define PCB_CMD_CFG_READ    4'hA
`define PCB_CMD_CFG_WRITE   4'hB

// ************************************************************
// Configuration address fields
// ************************************************************
`define PCB_TYPE_LO         1
`define PCB_TYPE_HI         0
`define PCB_TYPE0_CODE      2'h0
`define PCB_TYPE1_CODE      2'h1
`define PCB_REG_HI          7
`define PCB_REG_LO          2
`define PCB_FN_HI           10
`define PCB_FN_LO           8
`define PCB_DEV_HI          15
`define PCB_DEV_LO          11
`define PCB_BUS_HI          23
`define PCB_BUS_LO          16
`define PCB_SEL_HI          31
`define PCB_SEL_LO          16
`define PCB_DEV_ALL_ONES    5'h1F
`define PCB_FN_ALL_ONES     3'h7
`define PCB_REG_ZERO        6'h00
`define PCB_IDSEL_COUNT     16

// ************************************************************
// Decoded actions
// ************************************************************
`define PCB_ACT_TRANSLATE   2'h0
`define PCB_ACT_FWD_DOWN    2'h1
`define PCB_ACT_FWD_UP      2'h2
`define PCB_ACT_SPECIAL     2'h3

// ************************************************************
// Answers to the initiator
// ************************************************************
`define PCB_RESP_NONE       2'h0
`define PCB_RESP_RETRY      2'h1
`define PCB_RESP_TRDY       2'h2
`define PCB_RESP_ABORT_DATA 32'hFFFFFFFF

`endif

/* File: pcb_idsel_decode.v */
`timescale 1ns/1ps
`default_nettype none
`include "pcb_cfg_map.vh"

module pcb_idsel_decode
(
  input  wire [4:0]  deviceNumber,
  output reg  [15:0] idselPattern
);

  integer i;

  // One-hot select for devices 0..15, nothing above
  always @*
  begin
    idselPattern = 16'h0000;
    for (i = 0; i < `PCB_IDSEL_COUNT; i = i + 1)
    begin
      if (deviceNumber == i[4:0])
      begin
        idselPattern[i] = 1'b1;  // see RL4 RL5 RL6
      end
    end
  end

endmodule // pcb_idsel_decode

`default_nettype wire

/* File: pcb_cfg_classify.v */
`timescale 1ns/1ps
`default_nettype none
`include "pcb_cfg_map.vh"

module pcb_cfg_classify
(
  input  wire        fromPrimary,
  input  wire [31:0] addr,
  input  wire [3:0]  cmd,
  input  wire [7:0]  primaryBusNumber,
  input  wire [7:0]  secondaryBusNumber,
  input  wire [7:0]  subordinateBusNumber,
  input  wire [15:0] idselPattern,
  output reg         claim,
  output reg  [1:0]  action,
  output reg  [31:0] outAddr,
  output reg  [3:0]  outCmd,
  output reg         toSecondary
);

  // ************************************************************
  // Field extraction
  // ************************************************************
  wire [7:0] busNumber = addr[`PCB_BUS_HI:`PCB_BUS_LO];
  wire [4:0] devNumber = addr[`PCB_DEV_HI:`PCB_DEV_LO];
  wire [2:0] fnNumber  = addr[`PCB_FN_HI:`PCB_FN_LO];
  wire [5:0] regNumber = addr[`PCB_REG_HI:`PCB_REG_LO];
  wire       isWrite   = (cmd == `PCB_CMD_CFG_WRITE);
  wire       isConfig  = (cmd == `PCB_CMD_CFG_READ) || isWrite;
  wire       isType1   = (addr[`PCB_TYPE_LO:`PCB_TYPE_HI] == `PCB_TYPE1_CODE) && isConfig;
  wire       allOnes   = (devNumber == `PCB_DEV_ALL_ONES) && (fnNumber == `PCB_FN_ALL_ONES);
  wire       specForm  = isWrite && allOnes && (regNumber == `PCB_REG_ZERO);
  wire       inRange   = (busNumber > secondaryBusNumber) && (busNumber <= subordinateBusNumber);
  wire       outRange  = (busNumber < secondaryBusNumber) || (busNumber > subordinateBusNumber);

  // Decode of one address phase
  always @*
  begin
    claim       = 1'b0;
    action      = `PCB_ACT_TRANSLATE;
    outAddr     = addr;
    outCmd      = cmd;
    toSecondary = fromPrimary;
    if (isType1 && fromPrimary)
    begin
      if (busNumber == secondaryBusNumber)
      begin
        claim = 1'b1;  // see RL2
        if (specForm)
        begin
          action = `PCB_ACT_SPECIAL;  // see RL13 RL6
          outCmd = `PCB_CMD_SPECIAL;  // see RL14
        end
        else
        begin
          // Type 0 only ever downstream; see RL1 RL3
          outAddr = {idselPattern, 5'h00, fnNumber, regNumber, `PCB_TYPE0_CODE};
        end
      end
      else if (inRange)
      begin
        claim  = 1'b1;  // see RL9
        action = `PCB_ACT_FWD_DOWN;
      end
    end
    else if (isType1)
    begin
      if (specForm && (busNumber == primaryBusNumber))
      begin
        claim  = 1'b1;  // see RL13
        action = `PCB_ACT_SPECIAL;
        outCmd = `PCB_CMD_SPECIAL;  // see RL14
      end
      else if (isWrite && allOnes && outRange)
      begin
        claim  = 1'b1;  // see RL10
        action = `PCB_ACT_FWD_UP;
      end
    end
    // Everything else, special cycles included, is left alone; see RL12 RL17
  end

endmodule // pcb_cfg_classify

`default_nettype wire

/* File: pcb_cfg_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pcb_cfg_map.vh"
// ****************************************
// Port checker
// ****************************************
module pcb_cfg_props
(
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        clockEnable,
  input wire logic        primAddrValid,
  input wire logic        secAddrValid,
  input wire logic [3:0]  cmd_byte_enable_lines,
  input wire logic        primRespValid,
  input wire logic [1:0]  primRespCode,
  input wire logic        primRespDisconnect,
  input wire logic [1:0]  secRespCode,
  input wire logic        fwdValid,
  input wire logic        fwdToSecondary,
  input wire logic [31:0] fwdAddr,
  input wire logic [3:0]  fwdCmd,
  input wire logic        entryBusy
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Request taken, then entry queued
  sequence s_req; clockEnable && primAddrValid; endsequence
  sequence s_queued; primRespCode == `PCB_RESP_RETRY && $rose(entryBusy); endsequence
  property p_ans; s_req |=> primRespValid; endproperty
  a_ans: assert property (p_ans)
    else $error("no answer");
  property p_issue; s_req ##1 s_queued |=> fwdValid; endproperty
  a_issue: assert property (p_issue)
    else $error("cycle not issued");
  property p_t0sec; fwdValid && fwdAddr[1:0] == 2'h0 |-> fwdToSecondary; endproperty
  a_t0sec: assert property (p_t0sec)
    else $error("type 0 upstream");
  property p_sel;
    fwdValid && fwdAddr[1:0] == 2'h0 |-> $onehot0(fwdAddr[31:16]) && fwdAddr[15:11] == 5'h00;
  endproperty
  a_sel: assert property (p_sel)
    else $error("bad select");
  property p_spec; fwdValid && fwdCmd == `PCB_CMD_SPECIAL |-> fwdAddr[15:0] == 16'hFF01; endproperty
  a_spec: assert property (p_spec)
    else $error("bad special");
  property p_ign;
    clockEnable && secAddrValid && cmd_byte_enable_lines == `PCB_CMD_SPECIAL
      |=> secRespCode == `PCB_RESP_NONE;
  endproperty
  a_ign: assert property (p_ign)
    else $error("special claimed");
  property p_disc; primRespValid && primRespDisconnect |-> primRespCode == `PCB_RESP_TRDY; endproperty
  a_disc: assert property (p_disc)
    else $error("bad disconnect");
  property p_one; fwdValid |-> entryBusy; endproperty
  a_one: assert property (p_one)
    else $error("issue without entry");
endmodule // pcb_cfg_props
bind pcb_config_forward pcb_cfg_props pcb_cfg_props_i (.clock, .reset, .clockEnable,
  .primAddrValid, .secAddrValid, .cmd_byte_enable_lines, .primRespValid, .primRespCode,
  .primRespDisconnect, .secRespCode, .fwdValid, .fwdToSecondary, .fwdAddr, .fwdCmd,
  .entryBusy);
`default_nettype wire

/* File: pcb_tgt_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pcb_cfg_map.vh"
// ****************************************
// Target bus model
// ****************************************
module pcb_tgt_model
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        fwdValid,
  input  wire logic [31:0] fwdAddr,
  input  wire logic [3:0]  fwdCmd,
  input  wire logic        slow,
  output var  logic        tgtDone,
  output var  logic        tgtMasterAbort,
  output var  logic [31:0] tgtReadData
);
  logic       busy;
  logic       noTarget;
  logic [3:0] waitCount;
  // One cycle at a time; idle data toggles
  always @(posedge clock)
  begin
    tgtDone <= 1'b0;
    tgtMasterAbort <= 1'b0;
    tgtReadData <= ~tgtReadData;
    if (reset)
    begin
      busy <= 1'b0;
      tgtReadData <= 32'h00000000;
    end
    else if (fwdValid)
    begin
      busy <= 1'b1;
      waitCount <= slow ? 4'h7 : 4'h0;
      noTarget <= fwdCmd == `PCB_CMD_SPECIAL ||
                  (fwdAddr[1:0] == 2'h0 && fwdAddr[31:16] == 16'h0000);
    end
    else if (busy && waitCount != 4'h0)
      waitCount <= waitCount - 4'h1;
    else if (busy)
    begin
      busy <= 1'b0;
      tgtDone <= 1'b1;
      tgtMasterAbort <= noTarget;
      tgtReadData <= fwdAddr ^ 32'h5A5A5A5A;
    end
  end
endmodule // pcb_tgt_model
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pcb_cfg_map.vh"
// ****************************************
// Bench
// ****************************************
module testbench;
  logic        clock, reset, clockEnable, slow;
  logic [7:0]  primBus, secBus, subBus;
  logic        primAddrValid, primMultiPhase, secAddrValid, secMultiPhase;
  logic [31:0] primAddr, primData, secAddr, secData, a;
  logic [3:0]  primCmd, secCmd, fwdCmd;
  logic        tgtDone, tgtMasterAbort, rDisc;
  logic [31:0] tgtReadData, primReadData, secReadData, fwdAddr, fwdData, rData;
  logic [1:0]  primRespCode, secRespCode, rCode;
  logic        primRespValid, primRespDisconnect, secRespValid, secRespDisconnect;
  logic        fwdValid, fwdToSecondary, entryBusy;
  int          n_mismatch = 0;
  int          checked = 0;

  // Design and target model
  pcb_config_forward pcb_config_forward_i (.clock, .reset, .clockEnable,
    .primaryBusNumber(primBus), .secondaryBusNumber(secBus), .subordinateBusNumber(subBus),
    .primAddrValid, .primAddr, .primary_cmd_byte_enable(primCmd), .primData, .primMultiPhase,
    .secAddrValid, .secAddr, .cmd_byte_enable_lines(secCmd), .secData, .secMultiPhase,
    .tgtDone, .tgtMasterAbort, .tgtReadData, .primRespValid, .primRespCode,
    .primRespDisconnect, .primReadData, .secRespValid, .secRespCode, .secRespDisconnect,
    .secReadData, .fwdValid, .fwdToSecondary, .fwdAddr, .fwdCmd, .fwdData, .entryBusy);
  pcb_tgt_model pcb_tgt_model_i (.clock, .reset, .fwdValid, .fwdAddr, .fwdCmd, .slow,
    .tgtDone, .tgtMasterAbort, .tgtReadData);

  // Clock
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One address phase on either side, answer captured
  task req(input logic p, input logic [31:0] ad, input logic [3:0] c, input logic [31:0] d,
           input logic m);
    @(negedge clock);
    if (p)
      {primAddrValid, primAddr, primCmd, primData, primMultiPhase} = {1'b1, ad, c, d, m};
    else
      {secAddrValid, secAddr, secCmd, secData, secMultiPhase} = {1'b1, ad, c, d, m};
    @(negedge clock);
    {primAddrValid, secAddrValid, primAddr, secAddr} = {2'b00, ~ad, ~ad};
    check("valid", p ? primRespValid : secRespValid, 1'b1);
    {rCode, rData, rDisc} = p ? {primRespCode, primReadData, primRespDisconnect}
                              : {secRespCode, secReadData, secRespDisconnect};
  endtask

  task wait_done;
    for (int k = 0; k < 40 && tgtDone !== 1'b1; k++)
      @(negedge clock);
    check("done", tgtDone, 1'b1);
  endtask

  // Queue, complete on target bus, repeat
  task dly(input logic p, input logic [31:0] ad, input logic [3:0] c, input logic [31:0] d,
           input logic m, input logic [31:0] ea, input logic [3:0] ec, input logic es);
    req(p, ad, c, d, m);
    check("queue", rCode, `PCB_RESP_RETRY);
    check("addr", fwdAddr, ea);
    check("cmd", fwdCmd, ec);
    check("tosec", fwdToSecondary, es);
    if (c != `PCB_CMD_CFG_READ) check("wdata", fwdData, d);
    wait_done;
    req(p, ad, c, d, m);
    check("repeat", rCode, `PCB_RESP_TRDY);
    check("disc", rDisc, m);
    check("free", entryBusy, 1'b0);
    if (c == `PCB_CMD_CFG_READ) check("rdata", rData, (ea[31:16] == 16'h0000 &&
      ea[1:0] == 2'h0) ? `PCB_RESP_ABORT_DATA : ea ^ 32'h5A5A5A5A);
  endtask

  task refuse(input logic p, input logic [31:0] ad, input logic [3:0] c);
    req(p, ad, c, 32'h00000000, 1'b0);
    check("unclaimed", rCode, `PCB_RESP_NONE);
    check("no data", rData, 32'h00000000);
    check("no disc", rDisc, 1'b0);
  endtask

  // Request under a low clock enable is never taken
  task t_hold;
    @(negedge clock);
    {clockEnable, primAddrValid, primAddr, primCmd} =
      {1'b0, 1'b1, 8'h00, secBus, 16'h0805, `PCB_CMD_CFG_READ};
    @(negedge clock);
    check("frozen valid", primRespValid, 1'b0);
    check("frozen entry", entryBusy, 1'b0);
    {clockEnable, primAddrValid} = 2'b10;
    @(negedge clock);
    check("thawed entry", entryBusy, 1'b0);
  endtask

  task t_translate;
    for (int dev = 0; dev < 32; dev++)
    begin
      slow = dev[0];
      dly(1'b1, {8'h00, secBus, dev[4:0], 11'h215}, `PCB_CMD_CFG_READ, 32'h00000000, 1'b0,
          {(dev < 16) ? 16'h0001 << dev : 16'h0000, 16'h0214},
          `PCB_CMD_CFG_READ, 1'b1);
    end
    dly(1'b1, {8'h00, secBus, 16'h1A09}, `PCB_CMD_CFG_WRITE, 32'hC0DE0003, 1'b1,
        32'h00080208, `PCB_CMD_CFG_WRITE, 1'b1);
  endtask

  task t_special;
    a = {8'h00, secBus, 16'hFF01};
    dly(1'b1, a, `PCB_CMD_CFG_WRITE, 32'h0000A5C3, 1'b1, a, `PCB_CMD_SPECIAL, 1'b1);
    a = {8'h00, primBus, 16'hFF01};
    dly(1'b0, a, `PCB_CMD_CFG_WRITE, 32'h00003C5A, 1'b1, a, `PCB_CMD_SPECIAL, 1'b0);
  endtask

  task t_forward;
    a = {8'h00, subBus, 16'h1105};
    dly(1'b1, a, `PCB_CMD_CFG_READ, 32'h00000000, 1'b0, a, `PCB_CMD_CFG_READ, 1'b1);
    a = {8'h00, secBus + 8'h01, 16'hFF01};
    dly(1'b1, a, `PCB_CMD_CFG_WRITE, 32'h11112222, 1'b1, a, `PCB_CMD_CFG_WRITE, 1'b1);
    a = {8'h00, subBus + 8'h01, 16'hFF0D};
    dly(1'b0, a, `PCB_CMD_CFG_WRITE, 32'h33334444, 1'b0, a, `PCB_CMD_CFG_WRITE, 1'b0);
  endtask

  task t_refuse;
    refuse(1'b1, {8'h00, subBus + 8'h01, 16'h1001}, `PCB_CMD_CFG_READ);
    refuse(1'b1, {8'h00, secBus - 8'h01, 16'h1001}, `PCB_CMD_CFG_WRITE);
    refuse(1'b0, {8'h00, secBus, 16'hFF0D}, `PCB_CMD_CFG_WRITE);
    refuse(1'b0, {8'h00, 8'h20, 16'hFF05}, `PCB_CMD_CFG_READ);
    refuse(1'b0, {8'h00, 8'h20, 16'hFE05}, `PCB_CMD_CFG_WRITE);
    refuse(1'b1, {8'h00, secBus, 16'hFF01}, `PCB_CMD_SPECIAL);
    refuse(1'b0, 32'h0000FF01, `PCB_CMD_SPECIAL);
    refuse(1'b0, {8'h00, secBus, 16'h0804}, `PCB_CMD_CFG_READ);
  endtask

  task t_busy;
    a = {8'h00, secBus, 16'h0805};
    slow = 1'b1;
    req(1'b1, a, `PCB_CMD_CFG_READ, 32'h00000000, 1'b0);
    check("queued", rCode, `PCB_RESP_RETRY);
    req(1'b0, {8'h00, 8'h20, 16'hFF0D}, `PCB_CMD_CFG_WRITE, 32'h12345678, 1'b0);
    check("held off", rCode, `PCB_RESP_RETRY);
    check("entry kept", fwdToSecondary, 1'b1);
    req(1'b1, a, `PCB_CMD_CFG_READ, 32'h00000000, 1'b0);
    check("early repeat", rCode, `PCB_RESP_RETRY);
    wait_done;
    req(1'b1, a, `PCB_CMD_CFG_READ, 32'h00000000, 1'b0);
    check("late repeat", rCode, `PCB_RESP_TRDY);
    check("busy data", rData, 32'h00020004 ^ 32'h5A5A5A5A);
  endtask

  task conclude;
    $display("Checked %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #20000;
    n_mismatch++;
    conclude;
  end

  // Main sequence
  initial
  begin
    {clockEnable, slow, primBus, secBus, subBus} = {2'b10, 8'h02, 8'h05, 8'h09};
    {primAddrValid, primMultiPhase, secAddrValid, secMultiPhase} = 4'h0;
    {primAddr, primData, secAddr, secData, primCmd, secCmd} = '0;
    reset = 1'b1;
    repeat (3) @(negedge clock);
    reset = 1'b0;
    t_translate;
    t_special;
    t_forward;
    t_refuse;
    t_busy;
    t_hold;
    conclude;
  end
endmodule // testbench
`default_nettype wire
